// >>> dv/tb.sv
// Self-checking bench for the program/erase controller.
// Assumes eep_ctrl drives its array internally; bus driven at rising CLK.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import eep_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk;
  logic        reset;
  logic        ce;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [1:0]  mode_pin;
  logic [1:0]  op_mode;
  logic        hv_on;
  int          n_fail;
  int          checks_done;
  int          cycles;

  eep_ctrl eep_ctrl_inst
  (
    .CLK      (clk),
    .RESET    (reset),
    .CE       (ce),
    .ADDR     (addr),
    .WDATA    (wdata),
    .WR       (wr),
    .RD       (rd),
    .RDATA    (rdata),
    .MODE_PIN (mode_pin),
    .OP_MODE  (op_mode),
    .HV_ON    (hv_on)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk; // Bus clock above 1 MHz

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(rdata, exp);
  endtask

  // Latch, capture write, voltage on, wait, clear
  task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
                    input int n);
    wr_b(ADDR_CTL, c);
    wr_b(a, d);
    wr_b(ADDR_CTL, c | 8'h01);
    #1;
    chk({7'h00, hv_on}, 8'h01);
    repeat (n) @(posedge clk);
    wr_b(ADDR_CTL, 8'h00);
    #1;
    chk({7'h00, hv_on}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_regs();
    rd_chk(ADDR_BP, 8'h1f);
    rd_chk(ADDR_CTL, 8'h00);
    rd_chk(16'h0000, READ_UNMAPPED);
    wr_b(ADDR_BP, 8'h00);
    rd_chk(ADDR_BP, 8'h00);
  endtask

  task automatic t_refused_ctl();
    wr_b(ADDR_CTL, 8'h03);
    rd_chk(ADDR_CTL, 8'h00);
    chk({7'h00, hv_on}, 8'h00);
    wr_b(ADDR_CTL, 8'h01);
    rd_chk(ADDR_CTL, 8'h00);
  endtask

  task automatic t_option();
    op(8'h16, ADDR_OPT, 8'h00, 5);
    rd_chk(ADDR_OPT, 8'hff);
    op(8'h02, ADDR_OPT, 8'hf7, 5);
    rd_chk(ADDR_OPT, 8'hf7);
  endtask

  task automatic t_bulk();
    op(8'h06, ARR_BASE + 16'h0007, 8'h55, 600);
    rd_chk(ARR_BASE, 8'hff);
    rd_chk(ARR_BASE + 16'h01ff, 8'hff);
    rd_chk(ADDR_OPT, 8'hf7);
  endtask

  task automatic t_program();
    op(8'h1a, ARR_BASE + 16'h0005, 8'h5a, 5);
    rd_chk(ARR_BASE + 16'h0005, 8'h5a);
    rd_chk(ARR_BASE + 16'h0004, 8'hff);
    op(8'h02, ARR_BASE + 16'h0005, 8'h0f, 5);
    rd_chk(ARR_BASE + 16'h0005, 8'h0a);
    wr_b(ADDR_CTL, 8'h02);
    rd_chk(ARR_BASE + 16'h0005, 8'hff);
    wr_b(ADDR_CTL, 8'h00);
    rd_chk(ARR_BASE + 16'h0005, 8'h0a);
  endtask

  task automatic t_row_byte();
    op(8'h02, ARR_BASE + 16'h0010, 8'h00, 5);
    op(8'h02, ARR_BASE + 16'h001f, 8'h00, 5);
    op(8'h02, ARR_BASE + 16'h0020, 8'h00, 5);
    op(8'h0e, ARR_BASE + 16'h0013, 8'haa, 30);
    rd_chk(ARR_BASE + 16'h0010, 8'hff);
    rd_chk(ARR_BASE + 16'h001f, 8'hff);
    rd_chk(ARR_BASE + 16'h0020, 8'h00);
    op(8'h02, ARR_BASE + 16'h0030, 8'h00, 5);
    op(8'h02, ARR_BASE + 16'h0031, 8'h00, 5);
    op(8'h1e, ARR_BASE + 16'h0030, 8'h00, 5);
    rd_chk(ARR_BASE + 16'h0030, 8'hff);
    rd_chk(ARR_BASE + 16'h0031, 8'h00);
  endtask

  task automatic t_protect();
    wr_b(ADDR_BP, 8'h01);
    rd_chk(ADDR_BP, 8'h01);
    op(8'h02, ARR_BASE, 8'h00, 5);
    rd_chk(ARR_BASE, 8'hff);
    wr_b(ADDR_BP, 8'h00);
    rd_chk(ADDR_BP, 8'h01);
  endtask

  // Write with the clock enable low must leave the register alone
  task automatic t_clock_enable();
    @(posedge clk);
    ce <= 1'b0;
    wr_b(ADDR_CTL, 8'h02);
    ce <= 1'b1;
    rd_chk(ADDR_CTL, 8'h00);
  endtask

  task automatic t_security();
    @(posedge clk);
    reset    <= 1'b1;
    mode_pin <= 2'b01;
    repeat (3) @(posedge clk);
    reset    <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk({6'h00, op_mode}, {6'h00, MODE_SINGLE});
    rd_chk(ADDR_BP, 8'h1f);
    @(posedge clk);
    reset    <= 1'b1;
    mode_pin <= 2'b11;
    repeat (3) @(posedge clk);
    reset    <= 1'b0;
    repeat (70) @(posedge clk);
    #1;
    chk({6'h00, op_mode}, {6'h00, MODE_BOOT});
    wr_b(ADDR_BP, 8'h00);
    rd_chk(ADDR_BP, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    n_fail      = 0;
    checks_done = 0;
    cycles      = 0;
    reset       = 1'b1;
    ce          = 1'b1;
    addr        = 16'h0000;
    wdata       = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    mode_pin    = 2'b00;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset_regs();
    t_refused_ctl();
    t_option();
    t_bulk();
    t_program();
    t_row_byte();
    t_protect();
    t_clock_enable();
    t_security();
    end_sim();
  end
endmodule
`default_nettype wire

// >>> rtl/eep_array_mem.sv
// Nonvolatile cell array of 512 bytes plus the option word.
// Assumes content has no reset; cells keep what was last written.
`timescale 1ns/1ns
`default_nettype none
module eep_array_mem
  import eep_pkg::*;
(
  // Clock
  input wire logic CLK,
  input wire logic CE,
  // Controller side
  eep_mem_if.mem   mi
);

  logic [7:0] cells [ARR_DEPTH];
  logic [7:0] opt_q;
  logic [7:0] rdata_q;
  logic [7:0] new_val;
  logic [7:0] old_val;

  assign old_val  = mi.addr[9] ? opt_q : cells[mi.addr[8:0]];
  // Erase drives ones; programming can only pull ones to zero
  assign new_val  = mi.erase ? 8'hff : (old_val & mi.wdata);
  assign mi.rdata = rdata_q;
  assign mi.opt   = opt_q;

  always_ff @(posedge CLK)
  begin
    if (CE && mi.we)
    begin
      if (mi.addr[9])
        opt_q <= new_val;
      else
        cells[mi.addr[8:0]] <= new_val;
    end
    if (CE && mi.re)
      rdata_q <= old_val;
  end

endmodule
`default_nettype wire

// >>> rtl/eep_ctrl.sv
// Program/erase controller: control and block protect registers, array
// write capture, erase sweep, mode strap latch with security limit.
// Assumes a synchronous 8-bit bus; MODE_PIN is asynchronous.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Byte bit gives byte erase; else row bit row erase; else bulk.
// - Erase bit clear means program; set means erase.
// - Latch clear: reads served, no programming; latch set: reads locked.
// - Voltage enable bit switches the high voltage output.
// - Program ignores the row and byte select bits.
// - Clearing the control register drops voltage and restores reads.
// - Bulk erase covers the array and leaves the option word alone.
// - Option word erasable and programmable while its protect bit is clear.
// - Security active restricts modes to the single-chip ones.
// - Setting latch and voltage in one write while latch is clear sets neither.
// - Protect bits reset set; clear only in first 64 cycles normally.
// - Erased cells read one; programming only turns ones to zero.
// - Voltage bit writes work only while latch is already set.
module eep_ctrl
  import eep_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  // Processor bus
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output var  logic [7:0]  RDATA,
  // Mode straps and status
  input  wire logic [1:0]  MODE_PIN,
  output var  logic [1:0]  OP_MODE,
  output var  logic        HV_ON
);

  typedef struct packed {
    logic [7:0] ctl;
    logic [4:0] bp;
    logic [6:0] win;
    logic [1:0] msync1;
    logic [1:0] msync2;
    logic [1:0] mode;
    logic       cap_v;
    logic [9:0] cap_a;
    logic [7:0] cap_d;
    eep_st_e    st;
    logic [9:0] cnt;
    logic       rd_v;
    logic       rd_mem;
    logic [7:0] rd_reg;
    logic [7:0] rdata;
  } eep_ctl_s;

  eep_ctl_s s_q;
  eep_ctl_s s_d;

  eep_mem_if mi ();

  eep_array_mem u_mem (
    .CLK (CLK),
    .CE  (CE),
    .mi  (mi.mem)
  );

  // ----------------------------------------------------------------
  // Decode and sweep address
  // ----------------------------------------------------------------
  logic       in_arr;
  logic       is_opt;
  logic       latched;
  logic       single;
  logic       last;
  logic       sec;
  logic       normal;
  logic [9:0] bus_idx;
  logic [9:0] sweep_a;

  function automatic logic prot_of(input logic [9:0] a, input logic [4:0] bp);
    logic [1:0] b;
    b = (a[8:0] < BLK1_LO) ? 2'd0 : (a[8:0] < BLK2_LO) ? 2'd1 :
        (a[8:0] < BLK3_LO) ? 2'd2 : 2'd3;
    return a[9] ? bp[BP_OPT] : bp[b];
  endfunction

  assign in_arr  = (ADDR[15:9] == ARR_BASE[15:9]);
  assign is_opt  = (ADDR == ADDR_OPT);
  assign bus_idx = is_opt ? OPT_IDX : {1'b0, ADDR[8:0]};
  assign latched = s_q.ctl[CTL_LAT];
  assign sec     = ~mi.opt[OPT_SEC_BIT];
  assign normal  = (s_q.mode == MODE_SINGLE) || (s_q.mode == MODE_EXP);
  // Program and option targets are single-cell operations
  assign single  = !s_q.ctl[CTL_ERASE] || s_q.ctl[CTL_BYTE] || s_q.cap_a[9];
  assign sweep_a = single ? s_q.cap_a :
                   s_q.ctl[CTL_ROW] ? {s_q.cap_a[9:4], s_q.cnt[3:0]} : s_q.cnt;
  assign last    = single || (s_q.ctl[CTL_ROW] && s_q.cnt[3:0] == ROW_LAST) ||
                   (s_q.cnt == ARR_LAST);

  // ----------------------------------------------------------------
  // Array port
  // ----------------------------------------------------------------
  assign mi.re    = RD && (in_arr || is_opt) && !latched;
  assign mi.we    = (s_q.st == ST_RUN) && !prot_of(sweep_a, s_q.bp);
  assign mi.erase = s_q.ctl[CTL_ERASE];
  assign mi.addr  = (s_q.st == ST_RUN) ? sweep_a : bus_idx;
  assign mi.wdata = s_q.cap_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [1:0] raw;
    raw = s_q.msync2;
    s_d = s_q;
    s_d.msync1 = MODE_PIN;
    s_d.msync2 = s_q.msync1;
    if (s_q.win != PROT_WIN)
      s_d.win = s_q.win + 7'd1;
    // Strap latch after the synchroniser has filled
    if (s_q.win == MODE_LATCH_AT)
    begin
      if (sec && raw == MODE_EXP)
        s_d.mode = MODE_SINGLE;
      else if (sec && raw == MODE_TEST)
        s_d.mode = MODE_BOOT;
      else
        s_d.mode = raw;
    end

    if (WR && ADDR == ADDR_CTL)
    begin
      s_d.ctl = {3'b000, WDATA[4:2], WDATA[CTL_LAT],
                 latched ? WDATA[CTL_VPE] : 1'b0};
      if (!latched && WDATA[CTL_LAT] && WDATA[CTL_VPE])
        s_d.ctl[CTL_LAT] = 1'b0;
    end
    if (WR && ADDR == ADDR_BP)
    begin
      if (normal && s_q.win == PROT_WIN)
        s_d.bp = s_q.bp | WDATA[4:0];
      else
        s_d.bp = WDATA[4:0];
    end

    // Latched array writes capture the next operation
    if (WR && (in_arr || is_opt) && latched && s_q.st == ST_IDLE &&
        !s_q.ctl[CTL_VPE] && !prot_of(bus_idx, s_q.bp))
    begin
      s_d.cap_v = 1'b1;
      s_d.cap_a = bus_idx;
      s_d.cap_d = WDATA;
    end
    if (!s_d.ctl[CTL_LAT])
      s_d.cap_v = 1'b0;

    case (s_q.st)
      ST_IDLE:
      begin
        if (s_q.ctl[CTL_VPE] && s_q.cap_v)
        begin
          s_d.st  = ST_RUN;
          s_d.cnt = '0;
        end
      end
      ST_RUN:
      begin
        s_d.cnt = s_q.cnt + 10'd1;
        if (!s_q.ctl[CTL_VPE])
          s_d.st = ST_IDLE;
        else if (last)
          s_d.st = ST_DONE;
      end
      ST_DONE:
      begin
        if (!s_q.ctl[CTL_VPE])
          s_d.st = ST_IDLE;
      end
      default:
        s_d.st = ST_IDLE;
    endcase

    // Two-stage read: select, then data
    s_d.rd_v   = RD;
    s_d.rd_mem = (in_arr || is_opt) && !latched;
    if (ADDR == ADDR_CTL)
      s_d.rd_reg = s_q.ctl;
    else if (ADDR == ADDR_BP)
      s_d.rd_reg = {3'b000, s_q.bp};
    else if (in_arr || is_opt)
      s_d.rd_reg = READ_LOCKED;
    else
      s_d.rd_reg = READ_UNMAPPED;
    if (s_q.rd_v)
      s_d.rdata = s_q.rd_mem ? mi.rdata : s_q.rd_reg;
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      s_q      <= '0;
      s_q.ctl  <= CTL_RST;
      s_q.bp   <= BP_RST;
      s_q.st   <= ST_IDLE;
      s_q.mode <= MODE_SINGLE;
    end
    else if (CE)
      s_q <= s_d;
  end

  assign RDATA   = s_q.rdata;
  assign OP_MODE = s_q.mode;
  assign HV_ON   = s_q.ctl[CTL_VPE];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_both_set_refused: assert property (
    CE && WR && ADDR == ADDR_CTL && !latched && WDATA[1] && WDATA[0]
    |=> !s_q.ctl[CTL_LAT] && !HV_ON)
    else $error("latch and voltage set in one write");

  a_vpe_needs_latch: assert property (
    CE && WR && ADDR == ADDR_CTL && !latched |=> !HV_ON)
    else $error("voltage enabled without prior latch");

  a_clear_hv_off: assert property (
    CE && WR && ADDR == ADDR_CTL && WDATA == 8'h00
    |=> !HV_ON && !latched ##1 s_q.st != ST_RUN)
    else $error("clear did not return to read mode");

  a_read_locked: assert property (
    CE && RD && in_arr && latched ##1 CE |=> RDATA == READ_LOCKED)
    else $error("array readable while latched");

  a_prot_sticky: assert property (
    normal && s_q.win == PROT_WIN && $past(s_q.win) == PROT_WIN
    |-> (($past(s_q.bp) & ~s_q.bp) == 5'h00))
    else $error("protect bit cleared after window");

  a_no_prot_write: assert property (
    mi.we |-> !prot_of(mi.addr, s_q.bp))
    else $error("write to protected block");

  a_bulk_spares_opt: assert property (
    s_q.st == ST_RUN && !single && !s_q.ctl[CTL_ROW] |-> !mi.addr[9])
    else $error("bulk erase touched option word");

  a_row_span: assert property (
    s_q.st == ST_RUN && !single && s_q.ctl[CTL_ROW]
    |-> mi.addr[9:4] == s_q.cap_a[9:4])
    else $error("row erase left its row");

  a_prog_no_erase: assert property (
    mi.we && !s_q.ctl[CTL_ERASE] |-> !mi.erase && mi.addr == s_q.cap_a)
    else $error("program behaved as erase");

  a_secure_mode: assert property (
    CE && s_q.win == MODE_LATCH_AT && sec
    |=> OP_MODE == MODE_SINGLE || OP_MODE == MODE_BOOT)
    else $error("expanded mode under security");

  c_program: cover property (s_q.st == ST_RUN && !s_q.ctl[CTL_ERASE]);
  c_row: cover property (s_q.st == ST_RUN && s_q.ctl[CTL_ROW] && !single ##15 s_q.st == ST_DONE);
  c_bulk: cover property (s_q.st == ST_RUN && s_q.cnt == ARR_LAST);
  c_opt_erase: cover property (mi.we && mi.addr == OPT_IDX && mi.erase);

endmodule
`default_nettype wire

// >>> rtl/eep_mem_if.sv
// Port between the controller and the cell array.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface eep_mem_if;
  logic       re;
  logic       we;
  logic       erase;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] opt;

  modport ctl (output re, we, erase, addr, wdata, input rdata, opt);
  modport mem (input re, we, erase, addr, wdata, output rdata, opt);
endinterface
`default_nettype wire

// >>> rtl/eep_pkg.sv
// Constants, codes and types of the nonvolatile program/erase control block.
// Assumes an 8-bit processor bus with a 16-bit address on the block clock.
package eep_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CTL  = 16'h103b;
  localparam logic [15:0] ADDR_BP   = 16'h1035;
  localparam logic [15:0] ADDR_OPT  = 16'h103f;
  localparam logic [15:0] ARR_BASE  = 16'hb600;
  localparam int          ARR_DEPTH = 512;
  localparam logic [9:0]  OPT_IDX   = 10'h200;
  localparam logic [9:0]  ARR_LAST  = 10'h1ff;
  localparam logic [3:0]  ROW_LAST  = 4'hf;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_VPE   = 0;
  localparam int CTL_LAT   = 1;
  localparam int CTL_ERASE = 2;
  localparam int CTL_ROW   = 3;
  localparam int CTL_BYTE  = 4;
  localparam logic [7:0] CTL_RST = 8'h00;

  // ----------------------------------------------------------------
  // Block protect register and block bounds
  // ----------------------------------------------------------------
  localparam int         BP_OPT   = 4;
  localparam logic [4:0] BP_RST   = 5'h1f;
  localparam logic [8:0] BLK1_LO  = 9'h020;
  localparam logic [8:0] BLK2_LO  = 9'h060;
  localparam logic [8:0] BLK3_LO  = 9'h0e0;

  // ----------------------------------------------------------------
  // Option word, timing, read values
  // ----------------------------------------------------------------
  localparam int         OPT_SEC_BIT  = 3;
  localparam logic [6:0] PROT_WIN     = 7'd64;
  localparam logic [6:0] MODE_LATCH_AT = 7'd3;
  localparam logic [7:0] READ_LOCKED  = 8'hff;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_EXP    = 2'b01,
    MODE_BOOT   = 2'b10,
    MODE_TEST   = 2'b11
  } eep_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } eep_st_e;

endpackage
